// >>> core/pcib_pkg.sv
// Constants shared by the bridge I/O window configuration block
package pcib_pkg;

    // ========================================================================
    // Configuration dword offsets
    localparam logic [7:0] OFF_IO_UPPER   = 8'h30;
    localparam logic [7:0] OFF_CAP_PTR    = 8'h34;
    localparam logic [7:0] OFF_BRIDGE_CTL = 8'h3C;

    // ========================================================================
    // Field values and reset values
    localparam logic [7:0]  CAP_PTR_VALUE  = 8'hDC;
    localparam logic [7:0]  IRQ_PIN_VALUE  = 8'h00;
    localparam logic [15:0] IO_UPPER_RST   = 16'h0000;
    localparam logic        BCTL_BIT_RST   = 1'b0;
    localparam logic [31:0] UNMAPPED_READ  = 32'h0000_0000;

    // ========================================================================
    // Field positions
    localparam int IO_BASE_LSB    = 0;
    localparam int IO_LIMIT_LSB   = 16;
    localparam int IRQ_PIN_LSB    = 8;
    localparam int BCTL_PAR_BIT   = 16;
    localparam int BCTL_SERR_BIT  = 17;
    localparam int BCTL_ISA_BIT   = 18;

    // ========================================================================
    // Window geometry: 4 kB granularity, legacy filter in first 64 kB
    localparam int          IO_GRAN_BITS  = 12;
    localparam logic [11:0] IO_GRAN_ZERO  = 12'h000;
    localparam logic [11:0] IO_GRAN_ONES  = 12'hFFF;
    localparam logic [15:0] ISA_TOP_HALF  = 16'h0000;
    localparam logic [1:0]  ISA_LOW_QUART = 2'h0;

endpackage

// >>> core/pcib_win_if.sv
// Window bounds and filter mode passed from the registers to the decoders
`timescale 1ns/1ps
`default_nettype none

interface pcib_win_if;
    logic [15:0] base_hi;  // Base address bits 31:16
    logic [15:0] limit_hi; // Limit address bits 31:16
    logic [3:0]  base_lo;  // Base address bits 15:12
    logic [3:0]  limit_lo; // Limit address bits 15:12
    logic        isa_en;   // Legacy I/O filter enable

    modport regs (output base_hi, limit_hi, base_lo, limit_lo, isa_en);
    modport dec  (input  base_hi, limit_hi, base_lo, limit_lo, isa_en);
endinterface

`default_nettype wire

// >>> core/pcib_sync2.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module pcib_sync2 #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic core_clk, // System clock
    input  wire logic rst,      // Synchronous reset, active high
    input  wire logic d_in,     // Asynchronous input
    output logic      q_out     // Synchronised level
);
    logic meta_r;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            meta_r <= RST_VAL;
            q_out  <= RST_VAL;
        end
        else
        begin
            meta_r <= d_in;
            q_out  <= meta_r;
        end
    end
endmodule

`default_nettype wire

// >>> core/pcib_io_decode.sv
// I/O window and legacy filter decoder for one forwarding direction
`timescale 1ns/1ps
`default_nettype none

module pcib_io_decode #(
    parameter bit UPSTREAM = 1'b0
) (
    pcib_win_if.dec    win,  // Window bounds and filter mode
    input  wire logic [31:0] addr, // I/O address of the transaction
    output logic       hit   // Transaction is to be forwarded
);
    logic [31:0] full_base;
    logic [31:0] full_limit;
    logic        in_win;
    logic        isa_zone;
    logic        isa_cut;

    // Low 12 bits are implied, giving 4 kB alignment of both bounds
    assign full_base  = {win.base_hi, win.base_lo,
                         pcib_pkg::IO_GRAN_ZERO}; // RULE_03 RULE_17
    assign full_limit = {win.limit_hi, win.limit_lo,
                         pcib_pkg::IO_GRAN_ONES}; // RULE_03 RULE_17
    assign in_win     = (addr >= full_base) && (addr <= full_limit); // RULE_17
    // Last 768 bytes of each 1 kB block inside the first 64 kB
    assign isa_zone   = (addr[31:16] == pcib_pkg::ISA_TOP_HALF)
                     && (addr[9:8] != pcib_pkg::ISA_LOW_QUART);
    assign isa_cut    = win.isa_en && isa_zone && in_win;

    generate
        if (UPSTREAM)
        begin : g_up
            assign hit = !in_win || isa_cut;
        end
        else
        begin : g_down
            assign hit = in_win && !isa_cut;
        end
    endgenerate
endmodule

`default_nettype wire

// >>> core/pcib_io_window_regs.sv
// Bridge I/O window upper bounds, capability pointer and bridge control
//
// Functional notes
// (RULE_01) Dword 0x30 bits 15:0 hold base address bits 31:16, R/W, reset 0.
// (RULE_02) Dword 0x30 bits 31:16 hold limit address bits 31:16, R/W, reset 0.
// (RULE_03) Both window bounds have 4 kB granularity and alignment.
// (RULE_04) Software sets the upper base before relying on I/O forwarding.
// (RULE_05) Dword 0x34 bits 7:0 read 0xDC, the first capability offset.
// (RULE_06) Dword 0x34 bits 31:8 read zero and ignore writes.
// (RULE_07) Dword 0x3C bits 15:8 read zero since there is no interrupt pin.
// (RULE_08) With parity response off, no secondary parity error or report.
// (RULE_09) With parity response off, address parity raises no system error.
// (RULE_10) With parity response on, data parity errors drive the pin.
// (RULE_11) Address parity system errors need parity response set.
// (RULE_12) With forwarding off, secondary system error is not passed up.
// (RULE_13) Forwarding on plus driver enable passes secondary system error.
// (RULE_14) With legacy filter off, every in-window I/O goes downstream.
// (RULE_15) Legacy filter drops primary in-window low-64k last-768B cycles.
// (RULE_16) Legacy filter sends secondary last-768B cycles upstream. In-window, the code does so only in the first 64 kB.
// (RULE_17) Full bounds join upper and lower fields, compared inclusively.
`timescale 1ns/1ps
`default_nettype none

module pcib_io_window_regs (
    input  wire logic        core_clk,                // 10 MHz clock
    input  wire logic        rst,                     // Sync reset, high
    input  wire logic        cfg_req,                 // Config access pulse
    input  wire logic        cfg_we,                  // 1 write, 0 read
    input  wire logic [7:0]  cfg_addr,                // Dword byte offset
    input  wire logic [3:0]  primary_byte_enables_n,  // Lane enables, low
    input  wire logic [31:0] cfg_wdata,               // Write data
    output logic      [31:0] cfg_rdata_r,             // Read data
    output logic             cfg_ack_r,               // Access done pulse
    input  wire logic [3:0]  io_base_low,             // Base bits 15:12
    input  wire logic [3:0]  io_limit_low,            // Limit bits 15:12
    input  wire logic        primary_serr_enable,     // Command SERR enable
    input  wire logic        pri_io_valid,            // Primary I/O cycle
    input  wire logic [31:0] pri_io_addr,             // Primary I/O address
    output logic             pri_io_claim_r,          // Forward downstream
    input  wire logic        sec_io_valid,            // Secondary I/O cycle
    input  wire logic [31:0] sec_io_addr,             // Secondary address
    output logic             sec_io_claim_r,          // Forward upstream
    input  wire logic        sec_data_parity_err,     // Data parity pulse
    input  wire logic        sec_addr_parity_err,     // Addr parity pulse
    input  wire logic        sec_is_master,           // Bridge mastered cycle
    input  wire logic        secondary_system_error_in_n, // Pin, low
    output logic             secondary_parity_error_out_n_r, // Pin value
    output logic             secondary_parity_error_oe_r,    // Pin drive
    output logic             primary_system_error_out_n_r,   // Pin value
    output logic             primary_system_error_oe_r,      // Pin drive
    output logic             data_parity_reported_set_r,     // Status pulse
    output logic             parity_response_r,       // Bridge ctl bit 16
    output logic             system_error_forward_enable_r, // Bit 17
    output logic             legacy_io_filter_enable_r      // Bit 18
);

    // ========================================================================
    // Register state
    logic [15:0] base_hi_r;
    logic [15:0] base_hi_nxt;
    logic [15:0] limit_hi_r;
    logic [15:0] limit_hi_nxt;
    logic        par_nxt;
    logic        fwd_nxt;
    logic        isa_nxt;

    // ========================================================================
    // Access decode
    logic [3:0]  lane_en;
    logic        wr_io;
    logic        wr_ctl;
    logic        hit_io;
    logic        hit_cap;
    logic        hit_ctl;
    logic [31:0] io_word;
    logic [31:0] cap_word;
    logic [31:0] ctl_word;
    logic [31:0] rd_word;

    assign lane_en = ~primary_byte_enables_n;
    assign hit_io  = (cfg_addr == pcib_pkg::OFF_IO_UPPER);
    assign hit_cap = (cfg_addr == pcib_pkg::OFF_CAP_PTR);
    assign hit_ctl = (cfg_addr == pcib_pkg::OFF_BRIDGE_CTL);
    assign wr_io   = cfg_req && cfg_we && hit_io;
    assign wr_ctl  = cfg_req && cfg_we && hit_ctl && lane_en[2];

    // Each byte lane updates only its own byte of the word
    assign base_hi_nxt[7:0]   = (wr_io && lane_en[0]) ? cfg_wdata[7:0]
                              : base_hi_r[7:0];   // RULE_01
    assign base_hi_nxt[15:8]  = (wr_io && lane_en[1]) ? cfg_wdata[15:8]
                              : base_hi_r[15:8];  // RULE_01
    assign limit_hi_nxt[7:0]  = (wr_io && lane_en[2]) ? cfg_wdata[23:16]
                              : limit_hi_r[7:0];  // RULE_02
    assign limit_hi_nxt[15:8] = (wr_io && lane_en[3]) ? cfg_wdata[31:24]
                              : limit_hi_r[15:8]; // RULE_02

    assign par_nxt = wr_ctl ? cfg_wdata[pcib_pkg::BCTL_PAR_BIT]
                            : parity_response_r;
    assign fwd_nxt = wr_ctl ? cfg_wdata[pcib_pkg::BCTL_SERR_BIT]
                            : system_error_forward_enable_r;
    assign isa_nxt = wr_ctl ? cfg_wdata[pcib_pkg::BCTL_ISA_BIT]
                            : legacy_io_filter_enable_r;

    // Read words; everything not named here reads as zero
    assign io_word  = ({16'h0000, limit_hi_r} << pcib_pkg::IO_LIMIT_LSB)
                    | ({16'h0000, base_hi_r} << pcib_pkg::IO_BASE_LSB);
    assign cap_word = {24'h00_0000, pcib_pkg::CAP_PTR_VALUE};  // RULE_05 RULE_06
    assign ctl_word = ({31'h0, parity_response_r} << pcib_pkg::BCTL_PAR_BIT)
                    | ({31'h0, system_error_forward_enable_r}
                       << pcib_pkg::BCTL_SERR_BIT)
                    | ({31'h0, legacy_io_filter_enable_r}
                       << pcib_pkg::BCTL_ISA_BIT)
                    | ({24'h00_0000, pcib_pkg::IRQ_PIN_VALUE}
                       << pcib_pkg::IRQ_PIN_LSB);                // RULE_07
    assign rd_word  = hit_io  ? io_word  :
                      hit_cap ? cap_word :
                      hit_ctl ? ctl_word : pcib_pkg::UNMAPPED_READ;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            base_hi_r                     <= pcib_pkg::IO_UPPER_RST;
            limit_hi_r                    <= pcib_pkg::IO_UPPER_RST;
            parity_response_r             <= pcib_pkg::BCTL_BIT_RST;
            system_error_forward_enable_r <= pcib_pkg::BCTL_BIT_RST;
            legacy_io_filter_enable_r     <= pcib_pkg::BCTL_BIT_RST;
            cfg_rdata_r                   <= pcib_pkg::UNMAPPED_READ;
            cfg_ack_r                     <= 1'b0;
        end
        else
        begin
            base_hi_r                     <= base_hi_nxt;
            limit_hi_r                    <= limit_hi_nxt;
            parity_response_r             <= par_nxt;
            system_error_forward_enable_r <= fwd_nxt;
            legacy_io_filter_enable_r     <= isa_nxt;
            cfg_rdata_r <= (cfg_req && !cfg_we) ? rd_word : cfg_rdata_r;
            cfg_ack_r                     <= cfg_req;
        end
    end

    // ========================================================================
    // Forwarding decoders
    pcib_win_if win ();

    assign win.base_hi  = base_hi_r;
    assign win.limit_hi = limit_hi_r;
    assign win.base_lo  = io_base_low;
    assign win.limit_lo = io_limit_low;
    assign win.isa_en   = legacy_io_filter_enable_r;

    logic pri_hit;
    logic sec_hit;

    pcib_io_decode #(.UPSTREAM(1'b0)) u_down (
        .win  (win),
        .addr (pri_io_addr),
        .hit  (pri_hit)
    );

    pcib_io_decode #(.UPSTREAM(1'b1)) u_up (
        .win  (win),
        .addr (sec_io_addr),
        .hit  (sec_hit)
    );

    // ========================================================================
    // Error reporting
    logic serr_in_n;
    logic serr_lvl;
    logic perr_drive;
    logic serr_fwd;
    logic serr_apar;
    logic serr_drive;

    // Pin arrives from the secondary bus, so it is synchronised first
    pcib_sync2 #(.RST_VAL(1'b1)) u_serr_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .d_in     (secondary_system_error_in_n),
        .q_out    (serr_in_n)
    );

    assign serr_lvl   = !serr_in_n;
    assign perr_drive = parity_response_r
                     && sec_data_parity_err;  // RULE_08 RULE_10
    assign serr_fwd   = system_error_forward_enable_r && primary_serr_enable
                     && serr_lvl;             // RULE_12 RULE_13
    assign serr_apar  = parity_response_r && primary_serr_enable
                     && sec_addr_parity_err;  // RULE_09 RULE_11
    assign serr_drive = serr_fwd || serr_apar;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pri_io_claim_r                 <= 1'b0;
            sec_io_claim_r                 <= 1'b0;
            secondary_parity_error_out_n_r <= 1'b1;
            secondary_parity_error_oe_r    <= 1'b0;
            primary_system_error_out_n_r   <= 1'b1;
            primary_system_error_oe_r      <= 1'b0;
            data_parity_reported_set_r     <= 1'b0;
        end
        else
        begin
            pri_io_claim_r <= pri_io_valid && pri_hit; // RULE_14 RULE_15
            sec_io_claim_r                 <= sec_io_valid && sec_hit; // RULE_16
            secondary_parity_error_out_n_r <= !perr_drive;
            secondary_parity_error_oe_r    <= perr_drive;
            primary_system_error_out_n_r   <= !serr_drive;
            primary_system_error_oe_r      <= serr_drive;
            // Reported only when the bridge mastered the failing cycle
            data_parity_reported_set_r     <= perr_drive && sec_is_master;
        end
    end

    // ========================================================================
    // Checks
    logic [31:0] chk_base;
    logic [31:0] chk_limit;
    assign chk_base  = {base_hi_r, io_base_low, pcib_pkg::IO_GRAN_ZERO};
    assign chk_limit = {limit_hi_r, io_limit_low, pcib_pkg::IO_GRAN_ONES};

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    base_write_a: assert property (                                // RULE_01
        wr_io && (lane_en[1:0] == 2'h3)
        |=> (base_hi_r == $past(cfg_wdata[15:0])))
        else $error("base upper half not written");
    limit_write_a: assert property (                               // RULE_02
        wr_io && (lane_en[3:2] == 2'h3)
        |=> (limit_hi_r == $past(cfg_wdata[31:16])))
        else $error("limit upper half not written");
    cap_read_a: assert property (                          // RULE_05 RULE_06
        cfg_req && !cfg_we && hit_cap
        |=> cfg_ack_r && (cfg_rdata_r == 32'h0000_00DC))
        else $error("capability pointer read wrong");
    irq_pin_a: assert property (                                   // RULE_07
        cfg_req && !cfg_we && hit_ctl |=> (cfg_rdata_r[15:8] == 8'h00))
        else $error("interrupt pin not zero");
    perr_quiet_a: assert property (                                // RULE_08
        !parity_response_r
        |=> !secondary_parity_error_oe_r && !data_parity_reported_set_r)
        else $error("parity error driven while response off");
    perr_drive_a: assert property (                                // RULE_10
        parity_response_r && sec_data_parity_err
        |=> secondary_parity_error_oe_r && !secondary_parity_error_out_n_r)
        else $error("parity error not driven");
    apar_gate_a: assert property (                         // RULE_09 RULE_11
        !parity_response_r && !serr_fwd |=> !primary_system_error_oe_r)
        else $error("system error without cause");
    serr_block_a: assert property (                                // RULE_12
        !system_error_forward_enable_r && !serr_apar
        |=> !primary_system_error_oe_r)
        else $error("secondary system error forwarded while off");
    // Pin is judged two edges back, the latency of its synchroniser
    serr_pass_a: assert property (                                 // RULE_13
        system_error_forward_enable_r && primary_serr_enable
        && !$past(secondary_system_error_in_n, 2)
        && !$past(rst, 2) && !$past(rst)
        |=> primary_system_error_oe_r && !primary_system_error_out_n_r)
        else $error("secondary system error not forwarded");
    window_fwd_a: assert property (                // RULE_03 RULE_14 RULE_17
        pri_io_valid && !legacy_io_filter_enable_r
        && (pri_io_addr >= chk_base) && (pri_io_addr <= chk_limit)
        |=> pri_io_claim_r)
        else $error("in-window primary cycle not forwarded");
    isa_drop_a: assert property (                                  // RULE_15
        pri_io_valid && legacy_io_filter_enable_r
        && (pri_io_addr[31:16] == 16'h0000) && (pri_io_addr[9:8] != 2'h0)
        |=> !pri_io_claim_r)
        else $error("legacy cycle forwarded downstream");
    isa_up_a: assert property (                                    // RULE_16
        sec_io_valid && legacy_io_filter_enable_r
        && (sec_io_addr[31:16] == 16'h0000) && (sec_io_addr[9:8] != 2'h0)
        |=> sec_io_claim_r)
        else $error("legacy cycle not forwarded upstream");
    sec_inwin_a: assert property (                                 // RULE_17
        sec_io_valid && !legacy_io_filter_enable_r
        && (sec_io_addr >= chk_base) && (sec_io_addr <= chk_limit)
        |=> !sec_io_claim_r)
        else $error("in-window secondary cycle forwarded upstream");
    claim_idle_a: assert property (                        // RULE_14 RULE_16
        !pri_io_valid && !sec_io_valid |=> !pri_io_claim_r && !sec_io_claim_r)
        else $error("claim without a cycle");
    ack_pulse_a: assert property (
        cfg_req |=> cfg_ack_r)
        else $error("access not acknowledged");

    base_wr_c: cover property (wr_io ##1 pri_io_valid ##1 pri_io_claim_r);
    apar_c: cover property (serr_apar ##1 primary_system_error_oe_r);
    isa_c: cover property (legacy_io_filter_enable_r && pri_io_valid
                           && !pri_hit);
    serr_c: cover property (serr_fwd ##1 primary_system_error_oe_r);
    perr_c: cover property (perr_drive && sec_is_master
                            ##1 data_parity_reported_set_r);

endmodule

`default_nettype wire

// >>> test/pcib_sec_agent.sv
// Secondary bus agent: I/O cycles, parity error pulses and the error pin
`timescale 1ns/1ps
`default_nettype none

module pcib_sec_agent (
    input  wire logic        core_clk,                   // Bridge clock
    output logic             sec_io_valid,               // I/O cycle present
    output logic      [31:0] sec_io_addr,                // Cycle address
    output logic             sec_data_parity_err,        // Data parity pulse
    output logic             sec_addr_parity_err,        // Addr parity pulse
    output logic             sec_is_master,              // Bridge mastered
    output logic             secondary_system_error_in_n // Pulled-up pin
);
    initial
    begin
        sec_io_valid = 1'b0;
        sec_io_addr = 32'hFFFF_FFFF;
        sec_data_parity_err = 1'b0;
        sec_addr_parity_err = 1'b0;
        sec_is_master = 1'b0;
        secondary_system_error_in_n = 1'b1;
    end

    // ========================================================================
    // One I/O cycle; a released address bus shows the inverse, not old data
    task automatic io_cycle(input logic [31:0] a);
        @(negedge core_clk);
        sec_io_valid = 1'b1;
        sec_io_addr = a;
        @(negedge core_clk);
        sec_io_valid = 1'b0;
        sec_io_addr = ~a;
    endtask

    task automatic data_err(input logic m);
        @(negedge core_clk);
        sec_data_parity_err = 1'b1;
        sec_is_master = m;
        @(negedge core_clk);
        sec_data_parity_err = 1'b0;
        sec_is_master = ~m;
    endtask

    task automatic addr_err();
        @(negedge core_clk);
        sec_addr_parity_err = 1'b1;
        @(negedge core_clk);
        sec_addr_parity_err = 1'b0;
    endtask

    // Released pin floats up to its pull-up level
    task automatic pin(input logic lvl);
        @(negedge core_clk);
        secondary_system_error_in_n = lvl;
    endtask
endmodule

`default_nettype wire

// >>> test/pcib_io_window_regs_test.sv
// Self-checking bench for the bridge I/O window configuration block
`timescale 1ns/1ps
`default_nettype none

module pcib_io_window_regs_test;
    logic core_clk = 1'b0, rst = 1'b1, cfg_req = 1'b0, cfg_we = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [3:0] be_n = 4'hF, base_low = 4'h0, limit_low = 4'h0;
    logic [31:0] cfg_wdata = 32'h0000_0000, rdata, pri_addr = 32'h0000_0000;
    logic [31:0] s_addr, v;
    logic ack, pri_valid = 1'b0, pri_claim, sec_claim, serr_en = 1'b0;
    logic s_valid, d_err, a_err, s_mst, serr_in_n;
    logic perr_n, perr_oe, serr_n, serr_oe, rep, par, fwd, isa;
    int errors = 0, check_count = 0;

    always #50 core_clk = ~core_clk;

    pcib_io_window_regs pcib_io_window_regs_i (.core_clk(core_clk), .rst(rst),
        .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
        .primary_byte_enables_n(be_n), .cfg_wdata(cfg_wdata),
        .cfg_rdata_r(rdata), .cfg_ack_r(ack), .io_base_low(base_low),
        .io_limit_low(limit_low), .primary_serr_enable(serr_en),
        .pri_io_valid(pri_valid), .pri_io_addr(pri_addr),
        .pri_io_claim_r(pri_claim), .sec_io_valid(s_valid),
        .sec_io_addr(s_addr), .sec_io_claim_r(sec_claim),
        .sec_data_parity_err(d_err), .sec_addr_parity_err(a_err),
        .sec_is_master(s_mst), .secondary_system_error_in_n(serr_in_n),
        .secondary_parity_error_out_n_r(perr_n),
        .secondary_parity_error_oe_r(perr_oe),
        .primary_system_error_out_n_r(serr_n),
        .primary_system_error_oe_r(serr_oe),
        .data_parity_reported_set_r(rep), .parity_response_r(par),
        .system_error_forward_enable_r(fwd), .legacy_io_filter_enable_r(isa));

    pcib_sec_agent ptn (.core_clk(core_clk), .sec_io_valid(s_valid),
        .sec_io_addr(s_addr), .sec_data_parity_err(d_err),
        .sec_addr_parity_err(a_err), .sec_is_master(s_mst),
        .secondary_system_error_in_n(serr_in_n));

    // ========================================================================
    // Compare, bus and closing tasks
    task automatic chk1(input string nm, input logic e, input logic s);
        check_count++;
        if (s !== e)
        begin
            errors++;
            $display("wrong value %s expected %b seen %b", nm, e, s);
        end
    endtask

    task automatic chk32(input string nm, input logic [31:0] e,
                         input logic [31:0] s);
        check_count++;
        if (s !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Answer comes exactly one cycle after the request edge
    task automatic cfg(input logic we, input logic [7:0] a,
                       input logic [3:0] ben, input logic [31:0] wd);
        @(negedge core_clk);
        cfg_req = 1'b1;
        cfg_we = we;
        cfg_addr = a;
        be_n = ben;
        cfg_wdata = wd;
        @(negedge core_clk);
        cfg_req = 1'b0;
        cfg_wdata = ~wd;
        chk1("cfg_ack_r", 1'b1, ack);
        v = rdata;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        cfg(1'b0, a, 4'h0, 32'h0000_0000);
        chk32("cfg_rdata_r", e, v);
    endtask

    task automatic set_ctl(input logic [2:0] b);
        cfg(1'b1, 8'h3C, 4'h0, {13'h0000, b, 16'hFFFF});
        rd(8'h3C, {13'h0000, b, 16'h0000});
        chk32("ctl", {29'h0, b}, {29'h0, isa, fwd, par});
    endtask

    task automatic pri(input logic [31:0] a, input logic e);
        @(negedge core_clk);
        pri_valid = 1'b1;
        pri_addr = a;
        @(negedge core_clk);
        pri_valid = 1'b0;
        pri_addr = ~a;
        chk1("pri_io_claim_r", e, pri_claim);
    endtask

    task automatic sec(input logic [31:0] a, input logic e);
        ptn.io_cycle(a);
        chk1("sec_io_claim_r", e, sec_claim);
    endtask

    task automatic wait_oe(input logic e);
        int n;
        n = 0;
        while (serr_oe !== e && n < 8)
        begin
            @(negedge core_clk);
            n++;
        end
        chk1("primary_system_error_oe_r", e, serr_oe);
    endtask

    // ========================================================================
    // Scenarios
    task automatic t_reset();
        rd(8'h30, 32'h0000_0000);
        rd(8'h34, 32'h0000_00DC);
        rd(8'h3C, 32'h0000_0000);
        cfg(1'b1, 8'h34, 4'h0, 32'hFFFF_FFFF);
        rd(8'h34, 32'h0000_00DC);
        cfg(1'b1, 8'h40, 4'h0, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_lanes();
        cfg(1'b1, 8'h30, 4'hC, 32'hAAAA_1234);
        rd(8'h30, 32'h0000_1234);
        cfg(1'b1, 8'h30, 4'h3, 32'h5678_FFFF);
        rd(8'h30, 32'h5678_1234);
        $display("test lanes done");
    endtask

    task automatic t_window(input logic [2:0] c);
        set_ctl(c);
        base_low = 4'h1;
        limit_low = 4'h2;
        cfg(1'b1, 8'h30, 4'h0, 32'h0000_0000);
        pri(32'h0000_0FFF, 1'b0);
        pri(32'h0000_1000, 1'b1);
        pri(32'h0000_2FFF, !c[2]);
        pri(32'h0000_3000, 1'b0);
        pri(32'h0000_10FF, 1'b1);
        pri(32'h0000_1100, !c[2]);
        pri(32'h0000_13FF, !c[2]);
        sec(32'h0000_0FFF, 1'b1);
        sec(32'h0000_1000, 1'b0);
        sec(32'h0000_1100, c[2]);
        cfg(1'b1, 8'h30, 4'h0, 32'h0002_0001);
        pri(32'h0001_0FFF, 1'b0);
        pri(32'h0001_1100, 1'b1);
        pri(32'h0002_2FFF, 1'b1);
        pri(32'h0002_3000, 1'b0);
        $display("test window done");
    endtask

    task automatic t_perr();
        set_ctl(3'b000);
        ptn.data_err(1'b1);
        chk1("secondary_parity_error_oe_r", 1'b0, perr_oe);
        chk1("data_parity_reported_set_r", 1'b0, rep);
        set_ctl(3'b001);
        ptn.data_err(1'b1);
        chk1("secondary_parity_error_oe_r", 1'b1, perr_oe);
        chk1("secondary_parity_error_out_n_r", 1'b0, perr_n);
        chk1("data_parity_reported_set_r", 1'b1, rep);
        ptn.data_err(1'b0);
        chk1("data_parity_reported_set_r", 1'b0, rep);
        @(negedge core_clk);
        chk1("secondary_parity_error_oe_r", 1'b0, perr_oe);
        $display("test parity done");
    endtask

    task automatic t_serr();
        serr_en = 1'b1;
        set_ctl(3'b001);
        ptn.pin(1'b0);
        repeat (6) @(negedge core_clk);
        chk1("primary_system_error_oe_r", 1'b0, serr_oe);
        set_ctl(3'b011);
        wait_oe(1'b1);
        chk1("primary_system_error_out_n_r", 1'b0, serr_n);
        serr_en = 1'b0;
        wait_oe(1'b0);
        serr_en = 1'b1;
        ptn.pin(1'b1);
        set_ctl(3'b000);
        wait_oe(1'b0);
        ptn.addr_err();
        chk1("primary_system_error_oe_r", 1'b0, serr_oe);
        set_ctl(3'b001);
        ptn.addr_err();
        chk1("primary_system_error_oe_r", 1'b1, serr_oe);
        $display("test system error done");
    endtask

    initial
    begin
        #1_000_000;
        errors++;
        end_sim();
    end

    initial
    begin
        repeat (16) @(negedge core_clk);
        rst = 1'b0;
        t_reset();
        t_lanes();
        t_window(3'b000);
        t_window(3'b100);
        t_perr();
        t_serr();
        end_sim();
    end
endmodule

`default_nettype wire
